/* design/pcr_consts.svh */
// Offsets, field positions, reset values and timing counts of the power control block.
`ifndef PCR_CONSTS_SVH
`define PCR_CONSTS_SVH
`define PCR_OFF_CTRL 8'h0c
`define PCR_OFF_STAT 8'h10
`define PCR_OFF_MASK 8'h14
`define PCR_CTRL_RESET 16'h0060
`define PCR_CTRL_WMASK 16'h03ff
`define PCR_CTRL_FIXMASK 16'hfc7f
`define PCR_BIT_PFD 0
`define PCR_BIT_PF_WARN_IRQ_ENABLE 1
`define PCR_BIT_PFI 2
`define PCR_BIT_REGULATOR_STOP_KEEP_ON 3
`define PCR_BIT_TXOE 4
`define PCR_BIT_TXLVL 5
`define PCR_BIT_RXWP 6
`define PCR_BIT_PF_RESET_FLAG 7
`define PCR_BIT_INT_LO 8
`define PCR_BIT_INT_HI 9
`define PCR_EV_WARN 0
`define PCR_EV_PF_RESET_FLAG 1
`define PCR_CHK_CYC1 16'h0008
`define PCR_CHK_CYC2 16'h0040
`define PCR_CHK_CYC3 16'h0200
`define PCR_RESP_OKAY 2'h0
`define PCR_RESP_SLVERR 2'h2
`endif

/* design/pcr_pkg.sv */
// Types shared by the power control block.
package pcr_pkg;
   typedef enum logic [1:0] {SEL_NONE, SEL_CTRL, SEL_STAT, SEL_MASK} pcr_sel_t;

   typedef struct packed {
      logic awHeld;
      logic wHeld;
      logic [7:0] awAddr;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
   } pcr_axi_st_t;

   typedef struct packed {
      logic [15:0] count;
      logic pulse;
   } pcr_duty_st_t;

   typedef struct packed {
      logic [15:0] ctrl;
      logic [1:0] status;
      logic [1:0] mask;
      logic pfResetActive;
   } pcr_top_st_t;
endpackage

/* design/pcr_axil_slave.sv */
// AXI4-Lite slave front end of the power control block.
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_axil_slave (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wrEn,
   output logic [7:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrOk,
   output logic [7:0] rdAddr,
   input wire logic [31:0] rdData,
   input wire logic rdOk
);
   pcr_pkg::pcr_axi_st_t st_ff;
   pcr_pkg::pcr_axi_st_t nxt_st;

   assign s_axi_awready = !st_ff.awHeld && !st_ff.bValid;
   assign s_axi_wready = !st_ff.wHeld && !st_ff.bValid;
   assign s_axi_arready = !st_ff.rValid;
   assign wrEn = st_ff.awHeld && st_ff.wHeld && !st_ff.bValid;
   assign wrAddr = st_ff.awAddr;
   assign wrData = st_ff.wData;
   assign wrStrb = st_ff.wStrb;
   assign rdAddr = s_axi_araddr[7:0];
   assign s_axi_bvalid = st_ff.bValid;
   assign s_axi_bresp = st_ff.bResp;
   assign s_axi_rvalid = st_ff.rValid;
   assign s_axi_rdata = st_ff.rData;
   assign s_axi_rresp = st_ff.rResp;

   always_comb begin
      nxt_st = st_ff;
      if (s_axi_awvalid && s_axi_awready) begin
         nxt_st.awHeld = 1'b1;
         nxt_st.awAddr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         nxt_st.wHeld = 1'b1;
         nxt_st.wData = s_axi_wdata;
         nxt_st.wStrb = s_axi_wstrb;
      end
      if (wrEn) begin
         nxt_st.awHeld = 1'b0;
         nxt_st.wHeld = 1'b0;
         nxt_st.bValid = 1'b1;
         nxt_st.bResp = wrOk ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      end
      if (st_ff.bValid && s_axi_bready) begin
         nxt_st.bValid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         nxt_st.rValid = 1'b1;
         nxt_st.rData = rdData;
         nxt_st.rResp = rdOk ? `PCR_RESP_OKAY : `PCR_RESP_SLVERR;
      end else if (st_ff.rValid && s_axi_rready) begin
         nxt_st.rValid = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule

/* design/pcr_pf_duty.sv */
// Duty-cycle timer that paces supply-fail checks on ring oscillator ticks.
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_pf_duty (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ringTick,
   input wire logic [1:0] interval,
   input wire logic run,
   output logic checkPulse
);
   pcr_pkg::pcr_duty_st_t st_ff;
   pcr_pkg::pcr_duty_st_t nxt_st;

   function automatic logic [15:0] chkLimit(input logic [1:0] code);
      case (code)
         2'h1: chkLimit = `PCR_CHK_CYC1;
         2'h2: chkLimit = `PCR_CHK_CYC2;
         2'h3: chkLimit = `PCR_CHK_CYC3;
         default: chkLimit = 16'h0001;
      endcase
   endfunction

   assign checkPulse = st_ff.pulse;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.pulse = 1'b0;
      if (!run || interval == 2'h0) begin
         nxt_st.count = 16'h0000;
      end else if (ringTick) begin
         if (st_ff.count >= chkLimit(interval) - 16'h0001) begin
            nxt_st.count = 16'h0000;
            nxt_st.pulse = 1'b1;
         end else begin
            nxt_st.count = st_ff.count + 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   property p_pulse_single;
      @(posedge sys_clk) disable iff (!rst_b) checkPulse |=> !checkPulse;
   endproperty
   a_pulse_single: assert property (p_pulse_single) else $error("check pulse too long");
endmodule

/* design/pcr_top.sv */
// Power control register block: supply monitor, regulator, infrared pins and interrupts.
// ------------------------------------------------------------
// How it works
// - Regulator on keeps supply-fail monitor active; during supply-fail reset with nonzero interval, only on check pulses.
// - Stop with regulator off: disable bit gates comparator.
// - Warning flag and enable raise interrupt.
// - Warning flag sets below threshold; write clears.
// - Keep-on bit holds regulator in stop.
// - Timer off: drive and level bits set pin.
// - Timer on: timer owns the transmit pin.
// - Receive pull-up follows its select bit.
// - Supply-fail reset sets the reset flag.
// - Flag sets whenever the enabled monitor sees supply below reset threshold.
// - Check interval resets only at power-on.
// - Control register bits other than reset flag and interval take reset pattern on every reset, except warning flag while supply is below warning.
// ------------------------------------------------------------
`timescale 1ns/1ps
`include "pcr_consts.svh"
module pcr_top (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sysResetReq,
   input wire logic stopMode,
   input wire logic supplyBelowWarn,
   input wire logic supplyBelowReset,
   input wire logic ringOscTick,
   input wire logic irTimerOn,
   input wire logic irTimerTxLevel,
   input wire logic irTimerTxDrive,
   output logic pfCompEnable,
   output logic pfResetOut,
   output logic regulatorPower,
   output logic pfWarnIrq,
   output logic ir_tx_level,
   output logic ir_tx_drive_enable,
   output logic irTxPullup,
   output logic irRxPullup,
   output logic irq
);
   pcr_pkg::pcr_top_st_t st_ff;
   pcr_pkg::pcr_top_st_t nxt_st;
   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrOk;
   logic [7:0] rdAddr;
   logic [31:0] rdData;
   logic rdOk;
   logic checkPulse;
   logic monBase;
   logic syncReset;
   logic wrCtrl;
   logic [1:0] interval;
   logic [15:0] wrMask;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic pcr_pkg::pcr_sel_t regSel(input logic [7:0] addr);
      case (addr)
         `PCR_OFF_CTRL: regSel = pcr_pkg::SEL_CTRL;
         `PCR_OFF_STAT: regSel = pcr_pkg::SEL_STAT;
         `PCR_OFF_MASK: regSel = pcr_pkg::SEL_MASK;
         default: regSel = pcr_pkg::SEL_NONE;
      endcase
   endfunction

   pcr_axil_slave u_bus (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrOk(wrOk),
      .rdAddr(rdAddr),
      .rdData(rdData),
      .rdOk(rdOk)
   );

   pcr_pf_duty u_duty (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .ringTick(ringOscTick),
      .interval(interval),
      .run(st_ff.pfResetActive),
      .checkPulse(checkPulse)
   );

   assign wrOk = regSel(wrAddr) != pcr_pkg::SEL_NONE;
   assign rdOk = regSel(rdAddr) != pcr_pkg::SEL_NONE;
   assign wrCtrl = wrEn && regSel(wrAddr) == pcr_pkg::SEL_CTRL;
   assign wrMask = {{8{wrStrb[1]}}, {8{wrStrb[0]}}} & `PCR_CTRL_WMASK;
   assign interval = st_ff.ctrl[`PCR_BIT_INT_HI:`PCR_BIT_INT_LO];

   always_comb begin
      case (regSel(rdAddr))
         pcr_pkg::SEL_CTRL: rdData = {16'h0000, st_ff.ctrl & `PCR_CTRL_WMASK};
         pcr_pkg::SEL_STAT: rdData = {30'h0, st_ff.status};
         pcr_pkg::SEL_MASK: rdData = {30'h0, st_ff.mask};
         default: rdData = 32'h00000000;
      endcase
   end

   // ------------------------------------------------------------
   // Supply monitor and regulator
   // ------------------------------------------------------------
   assign regulatorPower = !stopMode || st_ff.ctrl[`PCR_BIT_REGULATOR_STOP_KEEP_ON];
   assign monBase = regulatorPower || !st_ff.ctrl[`PCR_BIT_PFD];
   assign pfCompEnable = monBase && (interval == 2'h0 || !st_ff.pfResetActive || checkPulse);
   assign pfResetOut = st_ff.pfResetActive;
   assign syncReset = sysResetReq || st_ff.pfResetActive;

   // ------------------------------------------------------------
   // Pins and interrupts
   // ------------------------------------------------------------
   assign pfWarnIrq = st_ff.ctrl[`PCR_BIT_PFI] && st_ff.ctrl[`PCR_BIT_PF_WARN_IRQ_ENABLE];
   assign ir_tx_drive_enable = irTimerOn ? irTimerTxDrive : st_ff.ctrl[`PCR_BIT_TXOE];
   assign ir_tx_level = irTimerOn ? irTimerTxLevel : st_ff.ctrl[`PCR_BIT_TXLVL];
   assign irTxPullup = !irTimerOn && !st_ff.ctrl[`PCR_BIT_TXOE] && st_ff.ctrl[`PCR_BIT_TXLVL];
   assign irRxPullup = st_ff.ctrl[`PCR_BIT_RXWP];
   assign irq = |(st_ff.status & st_ff.mask);

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      if (pfCompEnable) begin
         nxt_st.pfResetActive = supplyBelowReset;
      end
      if (syncReset) begin
         nxt_st.ctrl = (st_ff.ctrl & ~`PCR_CTRL_FIXMASK) | (`PCR_CTRL_RESET & `PCR_CTRL_FIXMASK);
      end else if (wrCtrl) begin
         nxt_st.ctrl = (st_ff.ctrl & ~wrMask) | (wrData[15:0] & wrMask);
      end
      if (supplyBelowWarn) begin
         nxt_st.ctrl[`PCR_BIT_PFI] = 1'b1;
      end
      if (pfCompEnable && supplyBelowReset) begin
         nxt_st.ctrl[`PCR_BIT_PF_RESET_FLAG] = 1'b1;
      end
      if (wrEn && regSel(wrAddr) == pcr_pkg::SEL_MASK) begin
         nxt_st.mask = wrData[1:0];
      end
      if (wrEn && regSel(wrAddr) == pcr_pkg::SEL_STAT) begin
         nxt_st.status = st_ff.status & ~wrData[1:0];
      end
      if (nxt_st.ctrl[`PCR_BIT_PFI] && !st_ff.ctrl[`PCR_BIT_PFI]) begin
         nxt_st.status[`PCR_EV_WARN] = 1'b1;
      end
      if (nxt_st.pfResetActive && !st_ff.pfResetActive) begin
         nxt_st.status[`PCR_EV_PF_RESET_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_ff <= '0;
         st_ff.ctrl <= `PCR_CTRL_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   property p_mon_reg_on;
      !stopMode && interval == 2'h0 && supplyBelowReset |=> pfResetOut;
   endproperty
   a_mon_reg_on: assert property (p_mon_reg_on) else $error("monitor missed low supply");

   property p_comp_off;
      stopMode && !st_ff.ctrl[`PCR_BIT_REGULATOR_STOP_KEEP_ON] && st_ff.ctrl[`PCR_BIT_PFD] |-> !pfCompEnable;
   endproperty
   a_comp_off: assert property (p_comp_off) else $error("comparator not shut down");

   property p_warn_irq;
      supplyBelowWarn && st_ff.ctrl[`PCR_BIT_PF_WARN_IRQ_ENABLE] && !syncReset && !wrCtrl |=> pfWarnIrq;
   endproperty
   a_warn_irq: assert property (p_warn_irq) else $error("warning interrupt missing");

   property p_warn_set;
      supplyBelowWarn |=> st_ff.ctrl[`PCR_BIT_PFI];
   endproperty
   a_warn_set: assert property (p_warn_set) else $error("warning flag not set");

   property p_reg_run;
      !stopMode |-> regulatorPower;
   endproperty
   a_reg_run: assert property (p_reg_run) else $error("regulator off outside stop");

   property p_tx_pullup;
      !irTimerOn && !st_ff.ctrl[`PCR_BIT_TXOE] && st_ff.ctrl[`PCR_BIT_TXLVL] |-> irTxPullup && !ir_tx_drive_enable;
   endproperty
   a_tx_pullup: assert property (p_tx_pullup) else $error("transmit pull-up wrong");

   property p_tx_timer;
      irTimerOn |-> ir_tx_drive_enable == irTimerTxDrive && ir_tx_level == irTimerTxLevel && !irTxPullup;
   endproperty
   a_tx_timer: assert property (p_tx_timer) else $error("timer does not own pin");

   property p_rx_pullup;
      wrCtrl && wrStrb[0] && !syncReset |=> irRxPullup == $past(wrData[`PCR_BIT_RXWP]);
   endproperty
   a_rx_pullup: assert property (p_rx_pullup) else $error("receive pull-up not updated");

   property p_pf_reset_flag_hold;
      pfResetOut |-> st_ff.ctrl[`PCR_BIT_PF_RESET_FLAG];
   endproperty
   a_pf_reset_flag_hold: assert property (p_pf_reset_flag_hold) else $error("reset flag clear in reset");

   property p_pf_reset_flag_set;
      pfCompEnable && supplyBelowReset |=> st_ff.ctrl[`PCR_BIT_PF_RESET_FLAG];
   endproperty
   a_pf_reset_flag_set: assert property (p_pf_reset_flag_set) else $error("reset flag not set");

   property p_int_keep;
      sysResetReq |=> interval == $past(interval);
   endproperty
   a_int_keep: assert property (p_int_keep) else $error("interval lost on reset");

   property p_reset_pat;
      syncReset && !supplyBelowWarn |=>
         (st_ff.ctrl & `PCR_CTRL_FIXMASK) == (`PCR_CTRL_RESET & `PCR_CTRL_FIXMASK);
   endproperty
   a_reset_pat: assert property (p_reset_pat) else $error("reset pattern wrong");

   property p_duty_gate;
      pfResetOut && interval != 2'h0 && !checkPulse |-> !pfCompEnable;
   endproperty
   a_duty_gate: assert property (p_duty_gate) else $error("monitor on between checks");

   // ------------------------------------------------------------
   // Pin, flag, monitor, regulator, interrupt and interval assertions; cover points
   // ------------------------------------------------------------
   property p_mon_on;
      regulatorPower && !pfResetOut |-> pfCompEnable;
   endproperty
   a_mon_on: assert property (p_mon_on) else $error("monitor off with regulator on");

   property p_mon_stop;
      stopMode && !st_ff.ctrl[`PCR_BIT_REGULATOR_STOP_KEEP_ON] && !st_ff.ctrl[`PCR_BIT_PFD] && !pfResetOut
         |-> pfCompEnable;
   endproperty
   a_mon_stop: assert property (p_mon_stop) else $error("stop monitor off");

   property p_irq_off;
      !st_ff.ctrl[`PCR_BIT_PF_WARN_IRQ_ENABLE] |-> !pfWarnIrq;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("warning interrupt not disabled");

   property p_warn_clr;
      wrCtrl && wrStrb[0] && !wrData[`PCR_BIT_PFI] && !supplyBelowWarn && !syncReset
         |=> !st_ff.ctrl[`PCR_BIT_PFI];
   endproperty
   a_warn_clr: assert property (p_warn_clr) else $error("warning flag not cleared");

   property p_reg_stop;
      stopMode |-> regulatorPower == st_ff.ctrl[`PCR_BIT_REGULATOR_STOP_KEEP_ON];
   endproperty
   a_reg_stop: assert property (p_reg_stop) else $error("regulator wrong in stop");

   property p_tx_drive;
      !irTimerOn && st_ff.ctrl[`PCR_BIT_TXOE]
         |-> ir_tx_drive_enable && !irTxPullup && ir_tx_level == st_ff.ctrl[`PCR_BIT_TXLVL];
   endproperty
   a_tx_drive: assert property (p_tx_drive) else $error("transmit drive wrong");

   property p_tx_hiz;
      !irTimerOn && !st_ff.ctrl[`PCR_BIT_TXOE] && !st_ff.ctrl[`PCR_BIT_TXLVL]
         |-> !ir_tx_drive_enable && !irTxPullup;
   endproperty
   a_tx_hiz: assert property (p_tx_hiz) else $error("transmit pin not floating");

   property p_rx_float;
      !st_ff.ctrl[`PCR_BIT_RXWP] |-> !irRxPullup;
   endproperty
   a_rx_float: assert property (p_rx_float) else $error("receive pull-up not off");

   property p_pf_reset_flag_other;
      sysResetReq && !supplyBelowReset |=> $stable(st_ff.ctrl[`PCR_BIT_PF_RESET_FLAG]);
   endproperty
   a_pf_reset_flag_other: assert property (p_pf_reset_flag_other) else $error("reset flag touched");

   property p_pf_reset_flag_event;
      pfCompEnable && supplyBelowReset && !pfResetOut |=> st_ff.status[`PCR_EV_PF_RESET_FLAG];
   endproperty
   a_pf_reset_flag_event: assert property (p_pf_reset_flag_event) else $error("reset event missing");

   property p_int_pf;
      pfResetOut |=> $stable(interval);
   endproperty
   a_int_pf: assert property (p_int_pf) else $error("interval lost in supply reset");

   property p_check_on;
      checkPulse && monBase |-> pfCompEnable;
   endproperty
   a_check_on: assert property (p_check_on) else $error("check pulse ignored");

   c_pf_reset: cover property (!pfResetOut ##1 pfResetOut);
   c_warn_irq: cover property (pfWarnIrq);
   c_timer_hand: cover property (irTimerOn ##1 !irTimerOn);
   c_irq: cover property (irq);
endmodule

/* tb/power_control_register_logic_tb_top.sv */
// Self-checking testbench of the power control register block.
`timescale 1ns/1ps
`include "pcr_consts.svh"
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t %s got %h exp %h", $time, m, g, e); end end

module power_control_register_logic_tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic sysResetReq = 1'b0, stopMode = 1'b0, supplyBelowWarn = 1'b0, supplyBelowReset = 1'b0;
   logic ringOscTick = 1'b0, irTimerOn = 1'b0, irTimerTxLevel = 1'b0, irTimerTxDrive = 1'b0;
   logic pfCompEnable, pfResetOut, regulatorPower, pfWarnIrq;
   logic ir_tx_level, ir_tx_drive_enable, irTxPullup, irRxPullup, irq;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [1:0] resp;
   logic [15:0] val;
   logic fell;

   always #25 sys_clk = ~sys_clk;

   pcr_top i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .sysResetReq(sysResetReq), .stopMode(stopMode),
      .supplyBelowWarn(supplyBelowWarn), .supplyBelowReset(supplyBelowReset),
      .ringOscTick(ringOscTick), .irTimerOn(irTimerOn), .irTimerTxLevel(irTimerTxLevel),
      .irTimerTxDrive(irTimerTxDrive), .pfCompEnable(pfCompEnable), .pfResetOut(pfResetOut),
      .regulatorPower(regulatorPower), .pfWarnIrq(pfWarnIrq), .ir_tx_level(ir_tx_level),
      .ir_tx_drive_enable(ir_tx_drive_enable), .irTxPullup(irTxPullup), .irRxPullup(irRxPullup), .irq(irq));

   // ------------------------------------------------------------
   // Bus tasks and expectations
   // ------------------------------------------------------------
   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awDone, wDone, awT, wT;
      awDone = 1'b0;
      wDone = 1'b0;
      @(posedge sys_clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(negedge sys_clk);
         awT = s_axi_awvalid && s_axi_awready;
         wT = s_axi_wvalid && s_axi_wready;
         @(posedge sys_clk);
         if (awT) begin
            s_axi_awvalid <= 1'b0;
            awDone = 1'b1;
         end
         if (wT) begin
            s_axi_wvalid <= 1'b0;
            wDone = 1'b1;
         end
      end
      do begin
         @(negedge sys_clk);
         awT = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge sys_clk);
      end while (!awT);
      s_axi_bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t;
      @(posedge sys_clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge sys_clk);
         t = s_axi_arready;
         @(posedge sys_clk);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge sys_clk);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge sys_clk);
      end while (!t);
      s_axi_rready <= 1'b0;
   endtask

   task automatic wrOk(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axiWrite(a, d, r);
      `CHK(r, `PCR_RESP_OKAY, "write response")
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(a, d, r);
      `CHK(r, `PCR_RESP_OKAY, "read response")
      `CHK(d, e, "read data")
   endtask

   function automatic logic [2:0] expTx(input logic [15:0] c, input logic on, input logic lv,
      input logic dr);
      if (on) begin
         return {lv, dr, 1'b0};
      end
      return {c[5], c[4], !c[4] && c[5]};
   endfunction

   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge sys_clk);
         ringOscTick <= 1'b1;
         @(posedge sys_clk);
         ringOscTick <= 1'b0;
      end
   endtask

   task automatic summarize;
      $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(70));
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      `CHK(irRxPullup, 1'b1, "rx pullup at reset")
      `CHK(regulatorPower, 1'b1, "regulator at reset")
      rdChk(`PCR_OFF_CTRL, 32'h0000_0060);
      rdChk(`PCR_OFF_STAT, 32'h0);
      rdChk(`PCR_OFF_MASK, 32'h0);
      axiWrite(8'h20, 32'hffff, resp);
      `CHK(resp, `PCR_RESP_SLVERR, "unmapped write")
      axiRead(8'h20, rd, resp);
      `CHK(resp, `PCR_RESP_SLVERR, "unmapped read")
      `CHK(rd, 32'h0, "unmapped data")
      for (int i = 0; i < 24; i++) begin
         val = 16'($urandom()) & 16'h007b;
         wrOk(`PCR_OFF_CTRL, {16'h0, val});
         stopMode <= 1'($urandom());
         irTimerOn <= 1'($urandom());
         irTimerTxLevel <= 1'($urandom());
         irTimerTxDrive <= 1'($urandom());
         @(negedge sys_clk);
         `CHK(regulatorPower, !stopMode || val[3], "regulator")
         `CHK(pfCompEnable, !stopMode || val[3] || !val[0], "monitor enable")
         `CHK({ir_tx_level, ir_tx_drive_enable, irTxPullup}, expTx(val, irTimerOn, irTimerTxLevel, irTimerTxDrive), "tx pin")
         `CHK(irRxPullup, val[6], "rx pullup")
         rdChk(`PCR_OFF_CTRL, {16'h0, val});
      end
      stopMode <= 1'b0;
      irTimerOn <= 1'b0;
      wrOk(`PCR_OFF_CTRL, 32'h2);
      wrOk(`PCR_OFF_MASK, 32'h1);
      supplyBelowWarn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(pfWarnIrq, 1'b1, "warn irq")
      `CHK(irq, 1'b1, "status irq")
      wrOk(`PCR_OFF_CTRL, 32'h2);
      rdChk(`PCR_OFF_CTRL, 32'h6);
      supplyBelowWarn <= 1'b0;
      wrOk(`PCR_OFF_CTRL, 32'h2);
      rdChk(`PCR_OFF_CTRL, 32'h2);
      @(negedge sys_clk);
      `CHK(pfWarnIrq, 1'b0, "warn irq cleared")
      rdChk(`PCR_OFF_STAT, 32'h1);
      wrOk(`PCR_OFF_STAT, 32'h1);
      @(negedge sys_clk);
      `CHK(irq, 1'b0, "status cleared")
      wrOk(`PCR_OFF_MASK, 32'h0);
      supplyBelowWarn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(irq, 1'b0, "masked irq")
      `CHK(pfWarnIrq, 1'b1, "warn irq ignores mask")
      wrOk(`PCR_OFF_CTRL, 32'h0);
      @(negedge sys_clk);
      `CHK(pfWarnIrq, 1'b0, "warn irq disabled")
      supplyBelowWarn <= 1'b0;
      wrOk(`PCR_OFF_STAT, 32'h3);
      wrOk(`PCR_OFF_CTRL, 32'h0000_0008);
      wrOk(`PCR_OFF_CTRL, 32'h0000_0108);
      supplyBelowReset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(pfResetOut, 1'b1, "supply-fail reset")
      @(posedge sys_clk);
      supplyBelowReset <= 1'b0;
      ticks(7);
      @(negedge sys_clk);
      `CHK(pfResetOut, 1'b1, "held until check")
      ticks(1);
      fell = 1'b0;
      for (int k = 0; k < 6 && !fell; k++) begin
         @(negedge sys_clk);
         fell = !pfResetOut;
      end
      `CHK(fell, 1'b1, "released at check")
      rdChk(`PCR_OFF_CTRL, 32'h0000_01e0);
      rdChk(`PCR_OFF_STAT, 32'h2);
      sysResetReq <= 1'b1;
      @(posedge sys_clk);
      sysResetReq <= 1'b0;
      rdChk(`PCR_OFF_CTRL, 32'h0000_01e0);
      wrOk(`PCR_OFF_CTRL, 32'h0000_0160);
      rdChk(`PCR_OFF_CTRL, 32'h0000_0160);
      for (int c = 2; c < 4; c++) begin
         wrOk(`PCR_OFF_CTRL, {22'h0, 2'(c), 8'h60});
         supplyBelowReset <= 1'b1;
         repeat (3) @(posedge sys_clk);
         supplyBelowReset <= 1'b0;
         ticks(c == 2 ? `PCR_CHK_CYC2 - 1 : `PCR_CHK_CYC3 - 1);
         @(negedge sys_clk);
         `CHK(pfResetOut, 1'b1, "held until long check")
         ticks(1);
         repeat (2) @(negedge sys_clk);
         `CHK(pfResetOut, 1'b0, "released at long check")
         rdChk(`PCR_OFF_CTRL, {22'h0, 2'(c), 8'he0});
      end
      rst_b <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1'b1;
      rdChk(`PCR_OFF_CTRL, 32'h0000_0060);
      summarize();
   end
endmodule
